// ===== verilog/lae_evaluator.sv
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "lae_defines.svh"
// What this block does
// - Night check gathers channel 0's datapoints from midnight to end time.
// - At window end, raise night alarm if no datapoint was at or below level.
// - Night alarm holds until next window end, then is judged again.
// - Night check uses neither hysteresis nor persistence.
// - Zero hysteresis clears the alarm as soon as the threshold is recrossed.
// - Upper limit sets at the limit, clears below limit minus hysteresis.
// - One-of-one persistence sets on the first qualifying datapoint.
// - Three-of-four sets on three in a row, else judges after fourth.
// - Global options apply the same to all eight alarm slots.
// - Clear messages are made only when clear notification is enabled.
// - Midnight resend makes an extra call while any alarm is active.
// - Immediate call-in calls at once; otherwise report at next scheduled call.
// - Active slot alarm (not the night alarm) with fast calling replaces schedule with in-alarm period.
// - On fault, logged value is last valid value or configured default.
// - SMS alarming places a separate call per stored destination, up to eight.
// - All triggers of one slot share its hysteresis and persistence.
// - Lower limit sets below limit, releases above limit plus hysteresis.
module lae_evaluator
    import lae_pkg::*;
#(
    parameter int NSLOT = 8,
    parameter int NCHAN = 8,
    parameter int MINUTE_CYCLES = int'(64'd3000000000 / 64'd1000000000 * 64'd1000)
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic dp_valid,
    input wire logic [2:0] dp_chan,
    input wire logic [15:0] dp_value,
    input wire logic dp_fault,
    input wire logic [10:0] time_of_day,
    input wire logic sched_call,
    input wire logic call_done,
    output logic [15:0] log_value,
    output logic log_valid,
    output logic call_req,
    output logic [1:0] call_kind,
    output logic [2:0] sms_dest,
    output logic irq
);
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] options;
    logic [10:0] night_end;
    logic [15:0] night_level;
    logic [15:0] fast_period;
    logic [15:0] fill_value;
    logic [7:0] sms_mask;
    logic [7:0] cfg [NSLOT];
    logic [15:0] upper [NSLOT];
    logic [15:0] lower [NSLOT];
    logic [15:0] hyst [NSLOT];
    logic [NSLOT-1:0] active;
    logic [3:0] hist [NSLOT];
    logic [15:0] last_good;
    logic night_seen;
    logic night_alarm;
    logic pend_report;
    logic [15:0] minute_count;
    logic [15:0] fast_count;
    lae_call_t call_state;
    logic [10:0] prev_tod;
    logic [15:0] call_count;

    // Bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire [7:0] ofs = wb_adr_i[7:0];
    wire in_slot = ofs >= `LAE_OFS_SLOT_BASE && ofs < 8'(`LAE_OFS_SLOT_BASE + NSLOT * `LAE_OFS_SLOT_STRIDE);
    wire [7:0] slot_ofs = ofs - `LAE_OFS_SLOT_BASE;
    wire [2:0] slot_idx = slot_ofs[6:4];
    wire [1:0] slot_word = slot_ofs[3:2];
    wire mapped = in_slot || ofs == `LAE_OFS_STATUS || ofs == `LAE_OFS_MASK
        || ofs == `LAE_OFS_OPTIONS || ofs == `LAE_OFS_NIGHT_END || ofs == `LAE_OFS_NIGHT_LEVEL
        || ofs == `LAE_OFS_FAST_PERIOD || ofs == `LAE_OFS_FILL_VALUE || ofs == `LAE_OFS_SMS_MASK
        || ofs == `LAE_OFS_ACTIVE || ofs == `LAE_OFS_CALLS;
    wire wr = bus_req && wb_we_i && mapped && ofs[1:0] == 2'b00;
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wdat = wb_dat_i & wmask;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (in_slot) begin
            unique case (slot_word)
                `LAE_SLOT_CFG: rdata = {24'h00_0000, cfg[slot_idx]};
                `LAE_SLOT_UPPER: rdata = {16'h0000, upper[slot_idx]};
                `LAE_SLOT_LOWER: rdata = {16'h0000, lower[slot_idx]};
                `LAE_SLOT_HYST: rdata = {16'h0000, hyst[slot_idx]};
            endcase
        end else begin
            case (ofs)
                `LAE_OFS_STATUS: rdata = {24'h00_0000, status};
                `LAE_OFS_MASK: rdata = {24'h00_0000, mask};
                `LAE_OFS_OPTIONS: rdata = {24'h00_0000, options};
                `LAE_OFS_NIGHT_END: rdata = {21'h00_0000, night_end};
                `LAE_OFS_NIGHT_LEVEL: rdata = {16'h0000, night_level};
                `LAE_OFS_FAST_PERIOD: rdata = {16'h0000, fast_period};
                `LAE_OFS_FILL_VALUE: rdata = {16'h0000, fill_value};
                `LAE_OFS_SMS_MASK: rdata = {24'h00_0000, sms_mask};
                `LAE_OFS_ACTIVE: rdata = {23'h00_0000, night_alarm, 8'(active)};
                `LAE_OFS_CALLS: rdata = {16'h0000, call_count};
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && mapped;
            wb_err_o <= bus_req && !mapped;
            wb_dat_o <= rdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask <= 8'h00;
            options <= `LAE_RST_OPTIONS;
            night_end <= `LAE_RST_NIGHT_END;
            night_level <= 16'h0000;
            fast_period <= `LAE_RST_FAST_PERIOD;
            fill_value <= `LAE_RST_FILL_VALUE;
            sms_mask <= 8'h00;
        end else if (wr && !in_slot) begin
            case (ofs)
                `LAE_OFS_MASK: mask <= 8'(merge({24'h0, mask}, wdat, wmask));
                `LAE_OFS_OPTIONS: options <= 8'(merge({24'h0, options}, wdat, wmask));
                `LAE_OFS_NIGHT_END: night_end <= 11'(merge({21'h0, night_end}, wdat, wmask));
                `LAE_OFS_NIGHT_LEVEL: night_level <= 16'(merge({16'h0, night_level}, wdat, wmask));
                `LAE_OFS_FAST_PERIOD: fast_period <= 16'(merge({16'h0, fast_period}, wdat, wmask));
                `LAE_OFS_FILL_VALUE: fill_value <= 16'(merge({16'h0, fill_value}, wdat, wmask));
                `LAE_OFS_SMS_MASK: sms_mask <= 8'(merge({24'h0, sms_mask}, wdat, wmask));
                default: ;
            endcase
        end
    end

    // Fault fill: last good or default
    wire [15:0] eff_value = !dp_fault ? dp_value : (options[`LAE_OPT_FILL_LAST] ? last_good : fill_value);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_good <= 16'h0000;
            log_value <= 16'h0000;
            log_valid <= 1'b0;
        end else begin
            log_valid <= dp_valid;
            if (dp_valid) begin
                log_value <= eff_value;
            end
            if (dp_valid && !dp_fault) begin
                last_good <= dp_value;
            end
        end
    end

    logic [NSLOT-1:0] set_ev;
    logic [NSLOT-1:0] clr_ev;
    genvar g;
    generate
        for (g = 0; g < NSLOT; g++) begin : slot
            // Shared hysteresis and persistence for both triggers
            wire mine = dp_valid && dp_chan == cfg[g][`LAE_CFG_CHAN_HI:`LAE_CFG_CHAN_LO];
            wire up_en = cfg[g][`LAE_CFG_UPPER_EN];
            wire lo_en = cfg[g][`LAE_CFG_LOWER_EN];
            wire [16:0] up_rel = {1'b0, upper[g]} - {1'b0, hyst[g]};
            wire [16:0] lo_rel = {1'b0, lower[g]} + {1'b0, hyst[g]};
            wire hit = (up_en && eff_value >= upper[g]) || (lo_en && eff_value < lower[g]);
            // Zero hysteresis collapses release to the limit
            wire release_ok = (!up_en || (!up_rel[16] && {1'b0, eff_value} < up_rel))
                && (!lo_en || {1'b0, eff_value} > lo_rel);
            wire [3:0] h_next = {hist[g][2:0], hit};
            wire three_row = h_next[2:0] == 3'b111;
            wire three_of_four = (4'(h_next[0]) + 4'(h_next[1]) + 4'(h_next[2]) + 4'(h_next[3])) >= 4'h3;
            wire confirm = cfg[g][`LAE_CFG_PERSIST] ? (three_row || three_of_four) : hit;
            assign set_ev[g] = mine && !active[g] && confirm;
            assign clr_ev[g] = mine && active[g] && release_ok;
            lae_history u_hist (
                .clk(clk),
                .resetn(resetn),
                .shift(mine),
                .hit(hit),
                .clr(set_ev[g] || clr_ev[g]),
                .hist(hist[g])
            );
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cfg[g] <= 8'h00;
                    upper[g] <= 16'h0000;
                    lower[g] <= 16'h0000;
                    hyst[g] <= 16'h0000;
                    active[g] <= 1'b0;
                end else begin
                    if (wr && in_slot && slot_idx == 3'(g)) begin
                        unique case (slot_word)
                            `LAE_SLOT_CFG: cfg[g] <= 8'(merge({24'h0, cfg[g]}, wdat, wmask));
                            `LAE_SLOT_UPPER: upper[g] <= 16'(merge({16'h0, upper[g]}, wdat, wmask));
                            `LAE_SLOT_LOWER: lower[g] <= 16'(merge({16'h0, lower[g]}, wdat, wmask));
                            `LAE_SLOT_HYST: hyst[g] <= 16'(merge({16'h0, hyst[g]}, wdat, wmask));
                        endcase
                    end
                    if (set_ev[g]) begin
                        active[g] <= 1'b1;
                    end else if (clr_ev[g]) begin
                        active[g] <= 1'b0;
                    end
                end
            end
            a_upper_set: assert property (@(posedge clk) disable iff (!resetn)
                mine && !cfg[g][`LAE_CFG_PERSIST] && up_en && eff_value >= upper[g] |=> active[g])
                else $error("upper hit did not activate");
            a_up_release: assert property (@(posedge clk) disable iff (!resetn)
                active[g] && mine && up_en && !lo_en && !up_rel[16] && {1'b0, eff_value} >= up_rel |=> active[g])
                else $error("alarm cleared inside hysteresis");
        end
    endgenerate

    // Night window: midnight to end time
    wire in_window = time_of_day < night_end;
    wire win_end = time_of_day == night_end && prev_tod != night_end;
    wire midnight = time_of_day == 11'h000 && prev_tod != 11'h000;
    wire night_dp = dp_valid && in_window && dp_chan == 3'h0 && eff_value <= night_level;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_tod <= 11'h000;
            night_seen <= 1'b0;
            night_alarm <= 1'b0;
        end else begin
            prev_tod <= time_of_day;
            if (win_end) begin
                night_alarm <= options[`LAE_OPT_NIGHT_EN] && !night_seen;
                night_seen <= 1'b0;
            end else if (night_dp) begin
                night_seen <= 1'b1;
            end
        end
    end
    a_night_judge: assert property (@(posedge clk) disable iff (!resetn)
        win_end && options[`LAE_OPT_NIGHT_EN] && !night_seen |=> night_alarm)
        else $error("night alarm not raised");
    a_night_hold: assert property (@(posedge clk) disable iff (!resetn)
        night_alarm && !win_end |=> night_alarm)
        else $error("night alarm dropped early");

    wire any_set = |set_ev || (win_end && options[`LAE_OPT_NIGHT_EN] && !night_seen && !night_alarm);
    wire any_clr = (|clr_ev || (win_end && night_alarm && night_seen)) && options[`LAE_OPT_CLEAR_NOTE];
    wire any_active = |active || night_alarm;
    wire report_ev = any_set || any_clr;

    // Interrupts: set beats clear
    wire [7:0] st_set = {3'b000, midnight && any_active && options[`LAE_OPT_MIDNIGHT],
        dp_valid && dp_fault, win_end && !night_seen && options[`LAE_OPT_NIGHT_EN], any_clr, any_set};
    wire [7:0] st_clr = (wr && !in_slot && ofs == `LAE_OFS_STATUS) ? wdat[7:0] : 8'h00;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= 8'h00;
        end else begin
            status <= (status & ~st_clr) | st_set;
        end
    end
    assign irq = |(status & mask);

    // Fast call schedule in minutes
    wire minute_tick = minute_count == 16'(MINUTE_CYCLES - 1);
    wire fast_mode = |active && options[`LAE_OPT_FAST];
    wire fast_due = fast_mode && minute_tick && fast_count + 16'h0001 >= fast_period;
    wire sched_ok = sched_call && !fast_mode;
    wire immediate = report_ev && options[`LAE_OPT_IMMEDIATE];
    wire resend = midnight && any_active && options[`LAE_OPT_MIDNIGHT];
    wire call_trig = immediate || resend || fast_due || (sched_ok && pend_report) || sched_ok;
    logic sms_start;
    logic sms_busy;
    lae_sms_dest #(.NDEST(8)) u_sms (
        .clk(clk),
        .resetn(resetn),
        .start(sms_start),
        .dest_mask(sms_mask),
        .call_done(call_done && call_state == LAE_CALL_SMS),
        .busy(sms_busy),
        .dest(sms_dest)
    );
    assign sms_start = call_state == LAE_CALL_SERVER && call_done && options[`LAE_OPT_SMS] && |sms_mask;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            minute_count <= 16'h0000;
            fast_count <= 16'h0000;
            pend_report <= 1'b0;
            call_state <= LAE_CALL_IDLE;
            call_count <= 16'h0000;
        end else begin
            minute_count <= minute_tick ? 16'h0000 : minute_count + 16'h0001;
            if (!fast_mode || fast_due) begin
                fast_count <= 16'h0000;
            end else if (minute_tick) begin
                fast_count <= fast_count + 16'h0001;
            end
            // Deferred reports ride the next scheduled call
            if (report_ev && !options[`LAE_OPT_IMMEDIATE]) begin
                pend_report <= 1'b1;
            end else if (call_state == LAE_CALL_SERVER && call_done) begin
                pend_report <= 1'b0;
            end
            unique case (call_state)
                LAE_CALL_IDLE: begin
                    if (call_trig) begin
                        call_state <= LAE_CALL_SERVER;
                        call_count <= call_count + 16'h0001;
                    end
                end
                LAE_CALL_SERVER: begin
                    if (call_done) begin
                        call_state <= sms_start ? LAE_CALL_SMS : LAE_CALL_IDLE;
                    end
                end
                LAE_CALL_SMS: begin
                    if (!sms_busy) begin
                        call_state <= LAE_CALL_IDLE;
                    end
                end
                default: call_state <= LAE_CALL_IDLE;
            endcase
        end
    end
    assign call_req = call_state != LAE_CALL_IDLE && !(call_state == LAE_CALL_SMS && !sms_busy);
    assign call_kind = call_state;
    a_imm_call: assert property (@(posedge clk) disable iff (!resetn)
        immediate && call_state == LAE_CALL_IDLE |=> call_state == LAE_CALL_SERVER)
        else $error("immediate call not started");
    a_clear_gate: assert property (@(posedge clk) disable iff (!resetn)
        !options[`LAE_OPT_CLEAR_NOTE] && !any_set && !(wr && ofs == `LAE_OFS_STATUS) |=> !status[`LAE_ST_CLEAR] || $past(status[`LAE_ST_CLEAR]))
        else $error("clear note without option");
    a_midnight_call: assert property (@(posedge clk) disable iff (!resetn)
        resend && call_state == LAE_CALL_IDLE |=> call_req)
        else $error("midnight resend missing");
    a_fault_fill: assert property (@(posedge clk) disable iff (!resetn)
        dp_valid && dp_fault && !options[`LAE_OPT_FILL_LAST] |=> log_valid && log_value == $past(fill_value))
        else $error("fault fill wrong");
endmodule // lae_evaluator
`default_nettype wire

// ===== verilog/lae_defines.svh
`ifndef LAE_DEFINES_SVH
`define LAE_DEFINES_SVH

// Register byte offsets
`define LAE_OFS_STATUS 8'h00
`define LAE_OFS_MASK 8'h04
`define LAE_OFS_OPTIONS 8'h08
`define LAE_OFS_NIGHT_END 8'h0C
`define LAE_OFS_NIGHT_LEVEL 8'h10
`define LAE_OFS_FAST_PERIOD 8'h14
`define LAE_OFS_FILL_VALUE 8'h18
`define LAE_OFS_SMS_MASK 8'h1C
`define LAE_OFS_ACTIVE 8'h20
`define LAE_OFS_CALLS 8'h24
`define LAE_OFS_SLOT_BASE 8'h40
`define LAE_OFS_SLOT_STRIDE 8'h10
// Per-slot word offsets within stride
`define LAE_SLOT_CFG 2'h0
`define LAE_SLOT_UPPER 2'h1
`define LAE_SLOT_LOWER 2'h2
`define LAE_SLOT_HYST 2'h3

// Option bit positions
`define LAE_OPT_CLEAR_NOTE 0
`define LAE_OPT_MIDNIGHT 1
`define LAE_OPT_IMMEDIATE 2
`define LAE_OPT_FAST 3
`define LAE_OPT_FILL_LAST 4
`define LAE_OPT_SMS 5
`define LAE_OPT_NIGHT_EN 6

// Slot config bit positions
`define LAE_CFG_UPPER_EN 0
`define LAE_CFG_LOWER_EN 1
`define LAE_CFG_PERSIST 2
`define LAE_CFG_CHAN_LO 4
`define LAE_CFG_CHAN_HI 6

// Status bit positions
`define LAE_ST_ALARM 0
`define LAE_ST_CLEAR 1
`define LAE_ST_NIGHT 2
`define LAE_ST_FAULT 3
`define LAE_ST_MIDNIGHT 4

// Reset values
`define LAE_RST_OPTIONS 8'h4D
`define LAE_RST_NIGHT_END 11'h168
`define LAE_RST_FAST_PERIOD 16'h003C
`define LAE_RST_FILL_VALUE 16'hFFFF

`endif

// ===== verilog/lae_pkg.sv
package lae_pkg;
    typedef enum logic [1:0] {
        LAE_CALL_IDLE = 2'b00,
        LAE_CALL_SERVER = 2'b01,
        LAE_CALL_SMS = 2'b10
    } lae_call_t;
    typedef logic [15:0] lae_value_t;
endpackage

// ===== verilog/lae_history.sv
`timescale 1ns/1ns
`default_nettype none
module lae_history (
    input wire logic clk,
    input wire logic resetn,
    input wire logic shift,
    input wire logic hit,
    input wire logic clr,
    output logic [3:0] hist
);
    // Newest result in bit 0
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hist <= 4'h0;
        end else if (clr) begin
            hist <= 4'h0;
        end else if (shift) begin
            hist <= {hist[2:0], hit};
        end
    end
endmodule // lae_history
`default_nettype wire

// ===== verilog/lae_sms_dest.sv
`timescale 1ns/1ns
`default_nettype none
module lae_sms_dest #(
    parameter int NDEST = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [NDEST-1:0] dest_mask,
    input wire logic call_done,
    output logic busy,
    output logic [2:0] dest
);
    logic [NDEST-1:0] pend;
    logic [2:0] first;
    always_comb begin
        first = 3'h0;
        for (int i = NDEST - 1; i >= 0; i--) begin
            if (pend[i]) begin
                first = 3'(i);
            end
        end
    end
    assign busy = |pend;
    // One call per stored destination, lowest first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend <= '0;
            dest <= 3'h0;
        end else begin
            if (start && !busy) begin
                pend <= dest_mask;
            end else if (call_done && busy) begin
                pend[dest] <= 1'b0;
            end
            dest <= first;
        end
    end
endmodule // lae_sms_dest
`default_nettype wire

// ===== test/lae_server_model.sv
`timescale 1ns/1ns
`default_nettype none
module lae_server_model #(
    parameter int DELAY = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic call_req,
    input wire logic [1:0] call_kind,
    input wire logic [2:0] sms_dest,
    output logic call_done
);
    // Every call, server or SMS, is closed on its own by one done pulse
    int cnt;
    logic [4:0] calls[$];
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            call_done <= 1'b0;
        end else begin
            call_done <= 1'b0;
            if (call_req && !call_done) begin
                cnt <= cnt + 1;
                if (cnt >= DELAY) begin
                    cnt <= 0;
                    call_done <= 1'b1;
                    calls.push_back({call_kind, (call_kind == 2'd2) ? sms_dest : 3'd0});
                end
            end
        end
    end
endmodule // lae_server_model
`default_nettype wire

// ===== test/lae_evaluator_tb.sv
`timescale 1ns/1ns
`default_nettype none
module lae_evaluator_tb;
    import lae_pkg::*;
    logic clk = 0, resetn = 0, we = 0, cyc = 0, stb = 0, dp_valid = 0, dp_fault = 0, sched_call = 0;
    logic [31:0] adr = 0, wdat = 0, dat_o, rd;
    logic [2:0] dp_chan = 0;
    logic [15:0] dp_value = 0;
    logic [10:0] tod = 11'h000;
    logic ack, err, berr, log_valid, call_req, call_done, irq, lv;
    logic [15:0] log_value, lval;
    logic [1:0] call_kind;
    logic [2:0] sms_dest;
    int miscompares = 0, compares = 0, cycles = 0;
    always #10 clk = ~clk;
    lae_evaluator #(.MINUTE_CYCLES(10)) u_lae_evaluator (.clk(clk), .resetn(resetn), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .wb_err_o(err), .dp_valid(dp_valid), .dp_chan(dp_chan), .dp_value(dp_value),
        .dp_fault(dp_fault), .time_of_day(tod), .sched_call(sched_call), .call_done(call_done),
        .log_value(log_value), .log_valid(log_valid), .call_req(call_req), .call_kind(call_kind),
        .sms_dest(sms_dest), .irq(irq));
    lae_server_model #(.DELAY(3)) u_lae_server_model (.clk(clk), .resetn(resetn), .call_req(call_req),
        .call_kind(call_kind), .sms_dest(sms_dest), .call_done(call_done));
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Timeout far above the roughly 1000 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        rd = dat_o;
        berr = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd & m);
    endtask
    // Long settle so any call and its SMS follow-ups finish before the next step
    task automatic dp(input logic [2:0] c, input logic [15:0] v, input logic f);
        @(posedge clk);
        dp_valid <= 1'b1;
        dp_chan <= c;
        dp_value <= v;
        dp_fault <= f;
        @(posedge clk);
        dp_valid <= 1'b0;
        dp_fault <= 1'b0;
        @(posedge clk);
        lv = log_valid;
        lval = log_value;
        repeat (30) @(posedge clk);
    endtask
    task automatic act(input logic [31:0] e);
        rdc("active", 32'h0000_0020, e, 32'h0000_0007);
    endtask
    task automatic tset(input logic [10:0] t);
        @(posedge clk);
        tod <= t;
        repeat (30) @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rdc("options", 32'h0000_0008, 32'h0000_004D, 32'hFFFF_FFFF);
        rdc("night_end", 32'h0000_000C, 32'h0000_0168, 32'hFFFF_FFFF);
        rdc("fast_period", 32'h0000_0014, 32'h0000_003C, 32'hFFFF_FFFF);
        bus(1'b0, 32'h0000_003C, 32'h0000_0000);
        chk("unmapped_err", 32'h0000_0001, {31'h0, berr});
        wr(32'h0000_0008, 32'h0000_0005);
        wr(32'h0000_0004, 32'h0000_0003);
        wr(32'h0000_0040, 32'h0000_0011);
        wr(32'h0000_0044, 32'h0000_0050);
        wr(32'h0000_004C, 32'h0000_000A);
        wr(32'h0000_0050, 32'h0000_0025);
        wr(32'h0000_0054, 32'h0000_0032);
        wr(32'h0000_005C, 32'h0000_0000);
        wr(32'h0000_0060, 32'h0000_0032);
        wr(32'h0000_0068, 32'h0000_0014);
        wr(32'h0000_006C, 32'h0000_000A);
        u_lae_server_model.calls.delete();
        dp(3'd1, 16'h0050, 1'b0);
        act(32'h0000_0001);
        chk("irq_set", 32'h0000_0001, {31'h0, irq});
        chk("calls", 32'h0000_0001, u_lae_server_model.calls.size());
        dp(3'd1, 16'h0046, 1'b0);
        act(32'h0000_0001);
        dp(3'd1, 16'h0045, 1'b0);
        act(32'h0000_0000);
        rdc("status", 32'h0000_0000, 32'h0000_0003, 32'h0000_0003);
        wr(32'h0000_0000, 32'h0000_001F);
        chk("irq_clr", 32'h0000_0000, {31'h0, irq});
        wr(32'h0000_0008, 32'h0000_0004);
        dp(3'd1, 16'h005A, 1'b0);
        dp(3'd1, 16'h0032, 1'b0);
        rdc("status_noclr", 32'h0000_0000, 32'h0000_0001, 32'h0000_0003);
        dp(3'd2, 16'h0032, 1'b0);
        dp(3'd2, 16'h000A, 1'b0);
        dp(3'd2, 16'h003C, 1'b0);
        act(32'h0000_0000);
        dp(3'd2, 16'h0037, 1'b0);
        act(32'h0000_0002);
        dp(3'd3, 16'h0014, 1'b0);
        act(32'h0000_0002);
        dp(3'd3, 16'h0013, 1'b0);
        act(32'h0000_0006);
        dp(3'd3, 16'h001E, 1'b0);
        act(32'h0000_0006);
        dp(3'd3, 16'h001F, 1'b0);
        act(32'h0000_0002);
        wr(32'h0000_0008, 32'h0000_0000);
        u_lae_server_model.calls.delete();
        dp(3'd3, 16'h0005, 1'b0);
        chk("deferred", 32'h0000_0000, u_lae_server_model.calls.size());
        @(posedge clk);
        sched_call <= 1'b1;
        @(posedge clk);
        sched_call <= 1'b0;
        repeat (20) @(posedge clk);
        chk("sched", 32'h0000_0001, u_lae_server_model.calls.size());
        wr(32'h0000_0008, 32'h0000_0024);
        wr(32'h0000_001C, 32'h0000_0005);
        u_lae_server_model.calls.delete();
        dp(3'd1, 16'h0055, 1'b0);
        chk("sms_n", 32'h0000_0003, u_lae_server_model.calls.size());
        chk("sms_0", 32'h0000_0008, u_lae_server_model.calls[0]);
        chk("sms_1", 32'h0000_0010, u_lae_server_model.calls[1]);
        chk("sms_2", 32'h0000_0012, u_lae_server_model.calls[2]);
        wr(32'h0000_0018, 32'h0000_1234);
        dp(3'd4, 16'h0777, 1'b1);
        chk("fill_def", 32'h0000_1234, {16'h0, lval});
        wr(32'h0000_0008, 32'h0000_0010);
        dp(3'd4, 16'h0100, 1'b0);
        chk("log_valid", 32'h0000_0001, {31'h0, lv});
        dp(3'd4, 16'h0999, 1'b1);
        chk("fill_last", 32'h0000_0100, {16'h0, lval});
        wr(32'h0000_0008, 32'h0000_0042);
        wr(32'h0000_0010, 32'h0000_0010);
        dp(3'd0, 16'h0020, 1'b0);
        tset(11'h168);
        rdc("night_on", 32'h0000_0020, 32'h0000_0100, 32'h0000_0100);
        u_lae_server_model.calls.delete();
        tset(11'h000);
        chk("resend", 32'h0000_0001, u_lae_server_model.calls.size());
        rdc("night_hold", 32'h0000_0020, 32'h0000_0100, 32'h0000_0100);
        rdc("status_night", 32'h0000_0000, 32'h0000_0014, 32'h0000_0014);
        dp(3'd0, 16'h000A, 1'b0);
        tset(11'h168);
        rdc("night_off", 32'h0000_0020, 32'h0000_0000, 32'h0000_0100);
        wr(32'h0000_0014, 32'h0000_0002);
        u_lae_server_model.calls.delete();
        wr(32'h0000_0008, 32'h0000_0008);
        sched_call <= 1'b1;
        @(posedge clk);
        sched_call <= 1'b0;
        repeat (48) @(posedge clk);
        chk("fast", 32'h0000_0002, u_lae_server_model.calls.size());
        results();
    end
endmodule // lae_evaluator_tb
`default_nettype wire
